// >>> common/rbls_regs.svh
// register indices, field positions, reset values and timing of the self-test block
//
// Behaviour
// R01 - clean ram test finish sets pass flag
// R02 - ram go set clears pass and fail
// R03 - ram test failure sets fail flag
// R04 - failing lowest-quadrant address readable at 0x1b
// R05 - four ram quadrants tested in parallel
// R06 - failing word is address plus quadrant offset
// R07 - test pin low: 0x1b reads message word
// R08 - control bits 7 and 6 read zero
// R09 - digital loopback drives no external bus
// R10 - analog loopback goes through selected bus
// R11 - sync select high sends command sync
// R12 - sync select low sends data sync
// R13 - ram go needs test pin and bit 15
// R14 - loopback go needs test pin, self-clears
// R15 - bus select low bus a, high b
// R16 - loopback fails on encoding, parity, sync, data
// R17 - pass and fail exclusive, held until go
`ifndef RBLS_REGS_SVH
`define RBLS_REGS_SVH
// register indices, byte address is four times the index
`define RBLS_IDX_RXD    8'h02
`define RBLS_IDX_FADDR  8'h1b
`define RBLS_IDX_TXD    8'h1f
`define RBLS_IDX_CTRL   8'h28
`define RBLS_IDX_ISTAT  8'h30
`define RBLS_IDX_IEN    8'h31
`define RBLS_IDX_ICLR   8'h32
// control register fields
`define RBLS_B_TSTEN    15
`define RBLS_B_SEL_HI   13
`define RBLS_B_SEL_LO   11
`define RBLS_B_RBGO     10
`define RBLS_B_RAM_SELFTEST_PASS_FLAG   9
`define RBLS_B_RAM_SELFTEST_FAIL_FLAG   8
`define RBLS_B_LBANA    5
`define RBLS_B_LOOPBACK_SYNC_SELECT   4
`define RBLS_B_LBBUS    3
`define RBLS_B_LBGO     2
`define RBLS_B_LOOPBACK_PASS_FLAG   1
`define RBLS_B_LOOPBACK_FAIL_FLAG   0
// reset values
`define RBLS_RST_WORD   16'h0000
`define RBLS_RST_IRQ    4'h0
// quadrant spacing of the ram under test
`define RBLS_QSTRIDE    16'h2000
// sync half-bit patterns, three bit times
`define RBLS_SYNC_CMD   6'h38
`define RBLS_SYNC_DATA  6'h07
// half-bit time and clock period
`define RBLS_HALF_NS    500
`define RBLS_CLK_NS     50
`define RBLS_HALF_CYC   (`RBLS_HALF_NS / `RBLS_CLK_NS)
`endif

// >>> common/rbls_pkg.sv
// state types of the self-test block
`default_nettype none
package rbls_pkg;
	// ram test engine states
	typedef enum logic [1:0] {
		BS_IDLE = 2'b00, BS_FILL = 2'b01, BS_VERIFY = 2'b10, BS_WRITE = 2'b11
	} rbls_bist_st_t;
	// loopback engine states
	typedef enum logic [1:0] {
		LS_IDLE = 2'b00, LS_RUN = 2'b01, LS_CHECK = 2'b10
	} rbls_lb_st_t;
endpackage
`default_nettype wire

// >>> common/rbls_bist_if.sv
// control and result signals between the register block and the ram test engine
`default_nettype none
interface rbls_bist_if;
	logic        start;      // one-cycle start pulse
	logic [2:0]  pattern;    // test selection
	logic        done;       // one-cycle completion pulse
	logic        pass;       // with done: no error
	logic        fail;       // with done: error seen
	logic [15:0] fail_addr;  // address in lowest quadrant
	logic        fault_en;   // fault injection enable
	logic [1:0]  fault_quad; // quadrant with stuck bit
	logic [15:0] fault_addr; // word with stuck bit
	modport ctrl (output start, pattern, fault_en, fault_quad, fault_addr,
		input done, pass, fail, fail_addr);
	modport engine (input start, pattern, fault_en, fault_quad, fault_addr,
		output done, pass, fail, fail_addr);
endinterface
`default_nettype wire

// >>> verilog/rbls_bist.sv
// ram test engine: march over four quadrants at once
`default_nettype none
`include "rbls_regs.svh"
module rbls_bist #(
	parameter int QWORDS = 8192
) (
	// clock and reset
	input wire logic    pclk,
	input wire logic    presetn,
	// control side
	rbls_bist_if.engine bi
);
	localparam int         AW        = $clog2(QWORDS);
	localparam logic [3:0] LAST_STEP = 4'h8;

	logic [15:0]               mem [4][QWORDS]; // four quadrants
	rbls_pkg::rbls_bist_st_t   st_r;            // engine state
	logic [AW-1:0]             addr_r;          // word within quadrant
	logic [3:0]                step_r;          // pattern step
	logic                      done_r;          // completion pulse
	logic                      pass_r;          // pass with done
	logic                      fail_r;          // fail with done
	logic [15:0]               faddr_r;         // captured address
	logic                      mism;            // any quadrant mismatch
	logic                      last_addr;       // at top of quadrant
	logic                      wr_en;           // write all quadrants
	logic [15:0]               wr_data;         // word written

	// pattern sequence of the march
	function automatic logic [15:0] pat(input logic [3:0] k);
		case (k)
			4'h1: pat = 16'h5555;
			4'h2: pat = 16'haaaa;
			4'h3: pat = 16'h3333;
			4'h4: pat = 16'hcccc;
			4'h5: pat = 16'h0f0f;
			4'h6: pat = 16'hf0f0;
			4'h7: pat = 16'h00ff;
			4'h8: pat = 16'hff00;
			default: pat = 16'h0000;
		endcase
	endfunction

	assign last_addr = (addr_r == AW'(QWORDS - 1));
	assign wr_en     = (st_r == rbls_pkg::BS_FILL) || (st_r == rbls_pkg::BS_WRITE);
	assign wr_data   = (st_r == rbls_pkg::BS_FILL) ? 16'h0000 : pat(step_r);
	assign bi.done      = done_r;
	assign bi.pass      = pass_r;
	assign bi.fail      = fail_r;
	assign bi.fail_addr = faddr_r;

	// compare the same word of every quadrant; a fault flips bit 0 on read
	always_comb begin
		logic [15:0] rd;
		rd   = 16'h0000;
		mism = 1'b0;
		for (int q = 0; q < 4; q++) begin // [R05]
			rd = mem[q][addr_r];
			if (bi.fault_en && bi.fault_quad == 2'(q) && bi.fault_addr[AW-1:0] == addr_r) begin
				rd[0] = ~rd[0];
			end
			if (rd != pat(step_r)) begin
				mism = 1'b1;
			end
		end
	end

	// each step lands in all quadrants in the same cycle
	always_ff @(posedge pclk) begin
		if (wr_en) begin
			for (int q = 0; q < 4; q++) begin // [R05]
				mem[q][addr_r] <= wr_data;
			end
		end
	end

	// march sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r    <= rbls_pkg::BS_IDLE;
			addr_r  <= '0;
			step_r  <= 4'h0;
			done_r  <= 1'b0;
			pass_r  <= 1'b0;
			fail_r  <= 1'b0;
			faddr_r <= 16'h0000;
		end else begin
			done_r <= 1'b0;
			case (st_r)
				rbls_pkg::BS_IDLE: begin
					addr_r <= '0;
					step_r <= 4'h0;
					if (bi.start) begin
						st_r <= rbls_pkg::BS_FILL;
					end
				end
				rbls_pkg::BS_FILL: begin // clear whole ram first
					addr_r <= last_addr ? '0 : addr_r + 1'b1;
					if (last_addr) begin
						st_r <= rbls_pkg::BS_VERIFY;
					end
				end
				rbls_pkg::BS_VERIFY: begin
					if (mism) begin // stop at first error, keep low-quadrant address
						st_r    <= rbls_pkg::BS_IDLE;
						done_r  <= 1'b1;
						pass_r  <= 1'b0;
						fail_r  <= 1'b1;               // [R03]
						faddr_r <= 16'(addr_r);        // [R04] [R06]
					end else if (step_r != LAST_STEP) begin
						step_r <= step_r + 4'h1;
						st_r   <= rbls_pkg::BS_WRITE;
					end else if (last_addr) begin
						st_r   <= rbls_pkg::BS_IDLE;
						done_r <= 1'b1;
						pass_r <= 1'b1;                // [R01]
						fail_r <= 1'b0;
					end else begin
						addr_r <= addr_r + 1'b1;
						step_r <= 4'h0;
					end
				end
				rbls_pkg::BS_WRITE: begin
					st_r <= rbls_pkg::BS_VERIFY;
				end
				default: st_r <= rbls_pkg::BS_IDLE;
			endcase
		end
	end

	quad_lockstep_a: assert property (@(posedge pclk) disable iff (!presetn) // [R05]
		wr_en |=> mem[0][$past(addr_r)] == mem[3][$past(addr_r)])
		else $error("quadrants out of step");
	bist_excl_a: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
		done_r |-> pass_r != fail_r)
		else $error("bist pass and fail disagree");
endmodule
`default_nettype wire

// >>> verilog/rbls_top.sv
// ram self-test and loopback test control with apb registers
`default_nettype none
`include "rbls_regs.svh"
module rbls_top #(
	parameter int         QWORDS   = 8192,
	parameter logic [7:0] HALF_CYC = 8'(`RBLS_HALF_CYC)
) (
	// clock and reset
	input wire logic          pclk,
	input wire logic          presetn,
	// apb slave
	input wire logic          psel,
	input wire logic          penable,
	input wire logic          pwrite,
	input wire logic [11:0]   paddr,
	input wire logic [31:0]   pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	// device pins and status
	input wire logic          test_pin,
	input wire logic [15:0]   msg_info,
	// ram fault injection
	input wire logic          ram_fault_en,
	input wire logic [1:0]    ram_fault_quad,
	input wire logic [15:0]   ram_fault_addr,
	// serial bus a
	output logic              bus_a_tx,
	output logic              bus_a_tx_en,
	input wire logic          bus_a_rx,
	// serial bus b
	output logic              bus_b_tx,
	output logic              bus_b_tx_en,
	input wire logic          bus_b_rx,
	// interrupt
	output logic              irq
);
	rbls_bist_if bi ();

	////////////////////////////////////////////////////////////////////////
	// registers
	logic                    tsten_r;     // test enable, bit 15
	logic [2:0]              rbsel_r;     // ram pattern select
	logic                    rbgo_r;      // ram test running
	logic                    ram_selftest_pass_flag_r;    // ram test pass
	logic                    ram_selftest_fail_flag_r;    // ram test fail
	logic                    lbana_r;     // analog loopback
	logic                    loopback_sync_select_r;    // command sync
	logic                    lbbus_r;     // bus b
	logic                    lbgo_r;      // loopback running
	logic                    loopback_pass_flag_r;    // loopback pass
	logic                    loopback_fail_flag_r;    // loopback fail
	logic [15:0]             faddr_r;     // failing address
	logic [15:0]             txd_r;       // loopback transmit word
	logic [15:0]             rxd_r;       // loopback received word
	logic [3:0]              istat_r;     // sticky events
	logic [3:0]              ien_r;       // event enables
	logic                    irq_r;       // interrupt level
	logic                    rb_start_r;  // engine start pulse
	logic [31:0]             prdata_r;    // read data
	logic                    pready_r;    // access ready
	logic                    pslverr_r;   // unmapped access
	rbls_pkg::rbls_lb_st_t   lb_st_r;     // loopback state
	logic [39:0]             frame_r;     // half-bit frame out
	logic [39:0]             rxsh_r;      // half-bit frame in
	logic [5:0]              sym_r;       // half-bit index
	logic [7:0]              hc_r;        // cycles within half-bit
	logic                    tx_line_r;   // serial line out
	logic                    txa_r;       // bus a drive
	logic                    txa_en_r;    // bus a enable
	logic                    txb_r;       // bus b drive
	logic                    txb_en_r;    // bus b enable

	////////////////////////////////////////////////////////////////////////
	// bus decode
	logic [7:0]  idx;          // word index
	logic        aligned;      // word access inside map window
	logic        setup_acc;    // first access cycle
	logic        commit;       // access completes this edge
	logic        wr;           // committed write
	logic        hit_rxd, hit_faddr, hit_txd, hit_ctrl, hit_istat, hit_ien, hit_iclr;
	logic        mapped;       // address known
	logic        rb_go_set;    // ram test accepted
	logic        lb_go_set;    // loopback accepted
	logic [15:0] ctrl_word;    // control register image
	logic [15:0] rd_word;      // read mux
	logic [3:0]  ev;           // event pulses
	logic [3:0]  istat_nxt;    // sticky status next

	assign idx       = paddr[9:2];
	assign aligned   = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
	assign setup_acc = psel && penable && !pready_r;
	assign commit    = psel && penable && pready_r;
	assign wr        = commit && pwrite;
	assign hit_rxd   = aligned && (idx == `RBLS_IDX_RXD);
	assign hit_faddr = aligned && (idx == `RBLS_IDX_FADDR);
	assign hit_txd   = aligned && (idx == `RBLS_IDX_TXD);
	assign hit_ctrl  = aligned && (idx == `RBLS_IDX_CTRL);
	assign hit_istat = aligned && (idx == `RBLS_IDX_ISTAT);
	assign hit_ien   = aligned && (idx == `RBLS_IDX_IEN);
	assign hit_iclr  = aligned && (idx == `RBLS_IDX_ICLR);
	assign mapped    = hit_rxd | hit_faddr | hit_txd | hit_ctrl | hit_istat | hit_ien | hit_iclr;

	// start requests are taken only under the documented conditions
	assign rb_go_set = wr && hit_ctrl && pwdata[`RBLS_B_RBGO] && test_pin && tsten_r
		&& !rbgo_r; // [R13]
	assign lb_go_set = wr && hit_ctrl && pwdata[`RBLS_B_LBGO] && test_pin
		&& !lbgo_r; // [R14]

	// bits 14, 7 and 6 are hard zero
	assign ctrl_word = {tsten_r, 1'b0, rbsel_r, rbgo_r, ram_selftest_pass_flag_r, ram_selftest_fail_flag_r,
		2'b00, lbana_r, loopback_sync_select_r, lbbus_r, lbgo_r, loopback_pass_flag_r, loopback_fail_flag_r}; // [R08]

	// address 0x1b shows the failure address only in test mode
	assign rd_word = hit_ctrl  ? ctrl_word :
		hit_faddr ? (test_pin ? faddr_r : msg_info) : // [R04] [R07]
		hit_txd   ? txd_r :
		hit_rxd   ? rxd_r :
		hit_istat ? {12'h000, istat_r} :
		hit_ien   ? {12'h000, ien_r} : 16'h0000;

	////////////////////////////////////////////////////////////////////////
	// apb answer: one wait state, read data and error from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else begin
			pready_r  <= setup_acc;
			prdata_r  <= (setup_acc && !pwrite) ? {16'h0000, rd_word} : 32'h0000_0000;
			pslverr_r <= setup_acc && !mapped;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// ram test engine
	assign bi.start      = rb_start_r;
	assign bi.pattern    = rbsel_r;
	assign bi.fault_en   = ram_fault_en;
	assign bi.fault_quad = ram_fault_quad;
	assign bi.fault_addr = ram_fault_addr;

	rbls_bist #(
		.QWORDS (QWORDS)
	) u_bist (
		.pclk    (pclk),
		.presetn (presetn),
		.bi      (bi)
	);

	////////////////////////////////////////////////////////////////////////
	// loopback frame: sync, 16 manchester bits, odd parity
	function automatic logic [39:0] enc(input logic [15:0] w, input logic cmd);
		logic [39:0] f;
		f = 40'h00_0000_0000;
		f[39:34] = cmd ? `RBLS_SYNC_CMD : `RBLS_SYNC_DATA; // [R11] [R12]
		for (int i = 0; i < 16; i++) begin
			f[2*i+3] = w[i];
			f[2*i+2] = ~w[i];
		end
		f[1] = ~^w;
		f[0] = ^w;
		return f;
	endfunction

	logic        rx_line;     // looped line
	logic        lb_man_ok;   // every data and parity half-bit pair differs
	logic [15:0] lb_data;     // received data bits
	logic        lb_bad;      // any loopback error
	logic        lb_done;     // check cycle
	logic        half_end;    // last cycle of half-bit
	logic        tx_bit;      // current half-bit

	// digital loops the internal line, analog listens to the chosen bus
	assign rx_line  = lbana_r ? (lbbus_r ? bus_b_rx : bus_a_rx) : tx_line_r; // [R09] [R10] [R15]
	assign lb_done  = (lb_st_r == rbls_pkg::LS_CHECK);
	assign half_end = (hc_r == HALF_CYC - 8'h01);
	assign tx_bit   = frame_r[6'd39 - sym_r];

	// received frame decode
	always_comb begin
		lb_man_ok = 1'b1;
		lb_data   = 16'h0000;
		for (int i = 0; i < 17; i++) begin
			if (rxsh_r[2*i+1] == rxsh_r[2*i]) begin
				lb_man_ok = 1'b0;
			end
		end
		for (int i = 0; i < 16; i++) begin
			lb_data[i] = rxsh_r[2*i+3];
		end
	end

	// encoding, parity, sync type and data all checked
	assign lb_bad = !lb_man_ok || !(^{lb_data, rxsh_r[1]})
		|| (rxsh_r[39:34] != (loopback_sync_select_r ? `RBLS_SYNC_CMD : `RBLS_SYNC_DATA))
		|| (lb_data != txd_r); // [R16]

	// loopback sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lb_st_r   <= rbls_pkg::LS_IDLE;
			frame_r   <= 40'h00_0000_0000;
			rxsh_r    <= 40'h00_0000_0000;
			sym_r     <= 6'h00;
			hc_r      <= 8'h00;
			tx_line_r <= 1'b0;
		end else begin
			case (lb_st_r)
				rbls_pkg::LS_IDLE: begin
					tx_line_r <= 1'b0;
					sym_r     <= 6'h00;
					hc_r      <= 8'h00;
					if (lb_go_set) begin // sync choice written with the go bit applies now
						frame_r <= enc(txd_r, pwdata[`RBLS_B_LOOPBACK_SYNC_SELECT]); // [R11] [R12]
						lb_st_r <= rbls_pkg::LS_RUN;
					end
				end
				rbls_pkg::LS_RUN: begin
					tx_line_r <= tx_bit;
					hc_r      <= half_end ? 8'h00 : hc_r + 8'h01;
					if (hc_r == (HALF_CYC >> 1)) begin // sample mid half-bit
						rxsh_r <= {rxsh_r[38:0], rx_line};
					end
					if (half_end) begin
						sym_r <= sym_r + 6'h01;
						if (sym_r == 6'd39) begin
							lb_st_r <= rbls_pkg::LS_CHECK;
						end
					end
				end
				rbls_pkg::LS_CHECK: begin
					tx_line_r <= 1'b0;
					lb_st_r   <= rbls_pkg::LS_IDLE;
				end
				default: lb_st_r <= rbls_pkg::LS_IDLE;
			endcase
		end
	end

	// only the selected bus is driven, and only in analog mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txa_r    <= 1'b0;
			txa_en_r <= 1'b0;
			txb_r    <= 1'b0;
			txb_en_r <= 1'b0;
		end else begin
			txa_en_r <= (lb_st_r == rbls_pkg::LS_RUN) && lbana_r && !lbbus_r; // [R09] [R15]
			txb_en_r <= (lb_st_r == rbls_pkg::LS_RUN) && lbana_r && lbbus_r;  // [R10]
			txa_r    <= lbana_r && !lbbus_r && tx_line_r;
			txb_r    <= lbana_r && lbbus_r && tx_line_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control register, data words and result flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{tsten_r, rbsel_r, lbana_r, loopback_sync_select_r, lbbus_r} <= 7'h00;
			{rbgo_r, ram_selftest_pass_flag_r, ram_selftest_fail_flag_r}                  <= 3'h0;
			{lbgo_r, loopback_pass_flag_r, loopback_fail_flag_r}                  <= 3'h0;
			rb_start_r <= 1'b0;
			faddr_r    <= `RBLS_RST_WORD;
			txd_r      <= `RBLS_RST_WORD;
			rxd_r      <= `RBLS_RST_WORD;
		end else begin
			rb_start_r <= rb_go_set;
			if (wr && hit_ctrl) begin
				tsten_r  <= pwdata[`RBLS_B_TSTEN];
				rbsel_r  <= pwdata[`RBLS_B_SEL_HI:`RBLS_B_SEL_LO];
				lbana_r  <= pwdata[`RBLS_B_LBANA];
				loopback_sync_select_r <= pwdata[`RBLS_B_LOOPBACK_SYNC_SELECT];
				lbbus_r  <= pwdata[`RBLS_B_LBBUS];
			end
			if (wr && hit_txd) begin
				txd_r <= pwdata[15:0];
			end
			if (rb_go_set) begin // start clears old result
				rbgo_r   <= 1'b1;
				ram_selftest_pass_flag_r <= 1'b0; // [R02]
				ram_selftest_fail_flag_r <= 1'b0; // [R02]
			end else if (bi.done) begin // result held until next start
				rbgo_r   <= 1'b0;
				ram_selftest_pass_flag_r <= bi.pass;          // [R01] [R17]
				ram_selftest_fail_flag_r <= bi.fail;          // [R03] [R17]
				if (bi.fail) begin
					faddr_r <= bi.fail_addr;  // [R04]
				end
			end
			if (lb_go_set) begin
				lbgo_r   <= 1'b1;
				loopback_pass_flag_r <= 1'b0; // [R14]
				loopback_fail_flag_r <= 1'b0; // [R14]
			end else if (lb_done) begin
				lbgo_r   <= 1'b0;
				loopback_pass_flag_r <= !lb_bad; // [R17]
				loopback_fail_flag_r <= lb_bad;  // [R16]
				rxd_r    <= lb_data;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupts: sticky status, write-one clear, a new event beats the clear
	assign ev        = {lb_done && lb_bad, lb_done && !lb_bad, bi.done && bi.fail,
		bi.done && bi.pass};
	assign istat_nxt = (istat_r & ~((wr && hit_iclr) ? pwdata[3:0] : 4'h0)) | ev;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			istat_r <= `RBLS_RST_IRQ;
			ien_r   <= `RBLS_RST_IRQ;
			irq_r   <= 1'b0;
		end else begin
			istat_r <= istat_nxt;
			if (wr && hit_ien) begin
				ien_r <= pwdata[3:0];
			end
			irq_r <= |(istat_nxt & ((wr && hit_ien) ? pwdata[3:0] : ien_r));
		end
	end

	// outputs straight from flops
	assign prdata      = prdata_r;
	assign pready      = pready_r;
	assign pslverr     = pslverr_r;
	assign bus_a_tx    = txa_r;
	assign bus_a_tx_en = txa_en_r;
	assign bus_b_tx    = txb_r;
	assign bus_b_tx_en = txb_en_r;
	assign irq         = irq_r;

	////////////////////////////////////////////////////////////////////////
	// checks
	ctrl_unused_a: assert property (@(posedge pclk) disable iff (!presetn) // [R08]
		(setup_acc && !pwrite && hit_ctrl) |=> prdata_r[7:6] == 2'b00)
		else $error("unused control bits read non-zero");
	rb_go_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
		$rose(rbgo_r) |-> $past(test_pin) && $past(tsten_r))
		else $error("ram test started without test pin and enable");
	rb_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // [R02]
		rb_go_set |=> !ram_selftest_pass_flag_r && !ram_selftest_fail_flag_r && rbgo_r)
		else $error("ram flags not cleared at start");
	rb_pass_a: assert property (@(posedge pclk) disable iff (!presetn) // [R01]
		(bi.done && bi.pass) |=> ram_selftest_pass_flag_r && !ram_selftest_fail_flag_r && !rbgo_r)
		else $error("ram pass not reported");
	flags_excl_a: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
		!(ram_selftest_pass_flag_r && ram_selftest_fail_flag_r) && !(loopback_pass_flag_r && loopback_fail_flag_r))
		else $error("pass and fail set together");
	digital_quiet_a: assert property (@(posedge pclk) disable iff (!presetn) // [R09]
		!lbana_r |=> !txa_en_r && !txb_en_r)
		else $error("bus driven in digital loopback");
	msg_map_a: assert property (@(posedge pclk) disable iff (!presetn) // [R07]
		(setup_acc && !pwrite && hit_faddr && !test_pin) |=> prdata_r[15:0] == $past(msg_info))
		else $error("message word not mapped with test pin low");
	sync_pick_a: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
		lb_go_set |=> frame_r[39:34] == (loopback_sync_select_r ? `RBLS_SYNC_CMD : `RBLS_SYNC_DATA))
		else $error("wrong sync type in loopback frame");
	lb_fail_a: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
		(lb_done && lb_bad) |=> loopback_fail_flag_r && !lbgo_r)
		else $error("loopback error not flagged");
endmodule
`default_nettype wire

// >>> verification/test_rbls_top.sv
// self-checking bench for the ram self-test and loopback test block
`default_nettype none
`include "rbls_regs.svh"
module test_rbls_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int          HC     = 4;          // short half-bit for speed
	localparam logic [15:0] MSG    = 16'h5a3c;   // message word shown with pin low
	localparam logic [11:0] A_CTRL = 12'(`RBLS_IDX_CTRL) << 2;
	localparam logic [11:0] A_FADR = 12'(`RBLS_IDX_FADDR) << 2;
	localparam logic [11:0] A_RXD  = 12'(`RBLS_IDX_RXD) << 2;
	localparam logic [11:0] A_TXD  = 12'(`RBLS_IDX_TXD) << 2;
	localparam logic [11:0] A_IST  = 12'(`RBLS_IDX_ISTAT) << 2;
	localparam logic [11:0] A_IEN  = 12'(`RBLS_IDX_IEN) << 2;
	localparam logic [11:0] A_ICLR = 12'(`RBLS_IDX_ICLR) << 2;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic        pready, pslverr, rerr, irq, a_tx, a_en, b_tx, b_en;
	logic        test_pin = 1'b0, fen = 1'b0, brk = 1'b0, seen_a = 1'b0, seen_b = 1'b0;
	logic        seen_clr = 1'b0;                // wipes the bus-drive record
	logic [1:0]  fquad = 2'h0;                   // quadrant with stuck bit
	logic [15:0] faddr = 16'h0000;               // word with stuck bit
	logic [39:0] sh = 40'h0;                     // captured frame half-bits
	logic [7:0]  ph = 8'h00;                     // cycles into frame
	int          n_mismatch = 0, checks = 0;
	// loop each bus back; a released line shows the inverse of its current transmit output
	wire a_rx = a_en ? a_tx ^ brk : ~a_tx;
	wire b_rx = b_en ? b_tx ^ brk : ~b_tx;
	always #25 pclk = ~pclk;
	rbls_top #(.QWORDS(16), .HALF_CYC(8'(HC))) DUT (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .test_pin(test_pin),
		.msg_info(MSG), .ram_fault_en(fen), .ram_fault_quad(fquad), .ram_fault_addr(faddr),
		.bus_a_tx(a_tx), .bus_a_tx_en(a_en), .bus_a_rx(a_rx), .bus_b_tx(b_tx),
		.bus_b_tx_en(b_en), .bus_b_rx(b_rx), .irq(irq));
	////////////////////////////////////////////////////////////////////////////
	// frame monitor: which bus drove, and half-bits sampled mid-slot
	always @(posedge pclk) begin
		seen_a <= (seen_a & !seen_clr) | a_en;
		seen_b <= (seen_b & !seen_clr) | b_en;
		if (!(a_en | b_en)) ph <= 8'h00;
		else begin
			ph <= ph + 8'h01;
			if (int'(ph) % HC == HC / 2) sh <= {sh[38:0], a_en ? a_tx : b_tx};
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// one apb transfer, held until pready is sampled high
	task automatic xfer(input logic w, input logic [11:0] a, input logic [15:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// compare seen against expected
	task automatic chk(input string nm, input logic [39:0] s, input logic [39:0] e);
		checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	// start a test, then poll control until its go bit drops
	task automatic run(input logic [15:0] d, input int b);
		xfer(1'b1, A_CTRL, d);
		repeat (200) begin
			xfer(1'b0, A_CTRL, 16'h0000);
			if (rdat[b] === 1'b0) break;
		end
	endtask
	// verdict and end of run
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	// watchdog
	initial begin
		#2000000;
		n_mismatch++;
		close_out;
	end
	// main sequence
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		test_pin <= 1'b1;
		@(posedge pclk);
		xfer(1'b0, A_CTRL, 16'h0000);
		chk("ctrl reset", rdat, 40'h0);
		xfer(1'b1, A_CTRL, 16'hfffb);
		xfer(1'b0, A_CTRL, 16'h0000);
		chk("ctrl fields", rdat, 40'hb838);
		xfer(1'b1, A_CTRL, 16'h8800);
		run(16'h8c00, 10);
		chk("ram pass", rdat, 40'h8a00);
		fen <= 1'b1;
		fquad <= 2'h2;
		faddr <= 16'h0005;
		run(16'h8c00, 10);
		chk("ram fail", rdat, 40'h8900);
		xfer(1'b0, A_FADR, 16'h0000);
		chk("fail addr", rdat, 40'h5);
		test_pin <= 1'b0;
		fen <= 1'b0;
		xfer(1'b0, A_FADR, 16'h0000);
		chk("msg word", rdat, {24'h0, MSG});
		xfer(1'b1, A_CTRL, 16'h8c04);
		xfer(1'b0, A_CTRL, 16'h0000);
		chk("go no pin", rdat, 40'h8900);
		test_pin <= 1'b1;
		xfer(1'b1, A_TXD, 16'h1234);
		run(16'h8804, 2);
		chk("lb digital", rdat, 40'h8902);
		xfer(1'b0, A_RXD, 16'h0000);
		chk("lb rx data", rdat, 40'h1234);
		chk("no drive", {seen_a, seen_b}, 40'h0);
		run(16'h883c, 2);
		chk("lb analog b", rdat, 40'h893a);
		chk("bus b only", {seen_a, seen_b}, 40'h1);
		chk("cmd sync", sh[39:34], 40'(`RBLS_SYNC_CMD));
		seen_clr <= 1'b1;
		@(posedge pclk);
		seen_clr <= 1'b0;
		brk <= 1'b1;
		run(16'h8824, 2);
		chk("lb broken", rdat, 40'h8921);
		chk("bus a only", {seen_a, seen_b}, 40'h2);
		chk("data sync", sh[39:34], 40'(`RBLS_SYNC_DATA));
		chk("irq masked", irq, 40'h0);
		xfer(1'b1, A_IEN, 16'h000f);
		xfer(1'b0, A_IST, 16'h0000);
		chk("irq status", rdat, 40'hf);
		chk("irq high", irq, 40'h1);
		xfer(1'b1, A_ICLR, 16'h000f);
		xfer(1'b0, A_IST, 16'h0000);
		chk("irq cleared", {irq, rdat}, 40'h0);
		xfer(1'b0, 12'h3fc, 16'h0000);
		chk("unmapped", {rerr, rdat}, 40'h1_0000_0000);
		close_out;
	end
endmodule
`default_nettype wire
